// ---- hw/hsstat_top.sv ----
/*
  status byte logic of a hot swap controller: sticky and live alert flags,
  the alert-enable, threshold and control registers that steer them.
  assumes a serial slave engine that decodes register writes into one-cycle
  strobes and shifts out status_byte on a status read; all inputs synchronous to clk.
*/
`timescale 1ns/1ps

module hsstat_top #(
  parameter bit LATCH_OFF = 1'b1
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // analog front end and adc
  input  wire hsstat_pkg::hsstat_sense_t sense,
  // register writes from the serial engine
  input  wire hsstat_pkg::hsstat_wr_t    wr,
  // register read-back
  output logic [7:0]                  status_byte,
  output logic [7:0]                  alert_en,
  output logic [7:0]                  current_alert_threshold,
  output logic                        software_power_off
);
  import hsstat_pkg::*;

  hsstat_state_t state;
  hsstat_state_t next_state;

  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    return (v == 3'h7) ? v : 3'(v + 3'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic over_now;
  logic off_now;
  logic off_rise;
  logic adc_event;
  logic fail_event;
  logic clear_req;

  always_comb begin
    // upper eight bits only, the low nibble is below alarm resolution
    over_now   = sense.conv_current[11:4] > state.current_alert_threshold;
    off_now    = ~sense.on_pin | state.software_power_off;
    off_rise   = off_now & ~state.prev_off;
    adc_event  = (state.alert_en[AEN_OC1] && state.over_run >= OC_ALERT1_COUNT)
               | (state.alert_en[AEN_OC4] && state.over_run >= OC_ALERT4_COUNT);
    fail_event = sense.swap_failed & state.alert_en[AEN_FAIL];
    clear_req  = state.alert_en[AEN_CLEAR];

    next_state = state;
    if (sense.conv_valid) begin
      next_state.over_run = over_now ? sat_inc(state.over_run) : 3'h0;
    end
    next_state.conv_overcurrent_seen = (next_state.over_run >= OC_LIVE_COUNT);
    next_state.prev_off = off_now;

    // clear first, then set, so an event in the clearing cycle still lands
    if (clear_req) begin
      next_state.adc_alert         = 1'b0;
      next_state.swap_failure_flag = 1'b0;
      next_state.off_alert         = 1'b0;
      next_state.alert_en[AEN_CLEAR] = 1'b0;
    end
    if (adc_event) begin
      next_state.adc_alert = 1'b1;
    end
    if (fail_event) begin
      next_state.swap_failure_flag = 1'b1;
    end
    if (off_rise && state.alert_en[AEN_OFF]) begin
      next_state.off_alert = 1'b1;
    end

    if (wr.alert_en_we) begin
      next_state.alert_en = wr.wdata;
    end
    if (wr.threshold_we) begin
      next_state.current_alert_threshold = wr.wdata;
    end
    if (wr.control_we) begin
      next_state.software_power_off = wr.wdata[0];
    end

    next_state.hot_swap_status = 8'h00;
    next_state.hot_swap_status[BIT_CONV_OC]    = next_state.conv_overcurrent_seen;
    next_state.hot_swap_status[BIT_ADC_ALERT]  = next_state.adc_alert;
    next_state.hot_swap_status[BIT_TRIP_OFF]   = (LATCH_OFF && state.alert_en[AEN_FAIL])
                                               ? next_state.swap_failure_flag
                                               : sense.analog_trip_off;
    next_state.hot_swap_status[BIT_FAIL_ALERT] = next_state.swap_failure_flag;
    next_state.hot_swap_status[BIT_OFF_STATUS] = off_now;
    next_state.hot_swap_status[BIT_OFF_ALERT]  = next_state.off_alert;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state                         <= '0;
      state.alert_en                <= ALERT_EN_RESET;
      state.current_alert_threshold <= THRESHOLD_RESET;
      state.software_power_off      <= CONTROL_RESET[0];
      state.hot_swap_status         <= STATUS_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the serial engine samples this on the read address byte acknowledge
  assign status_byte             = state.hot_swap_status;
  assign alert_en                = state.alert_en;
  assign current_alert_threshold = state.current_alert_threshold;
  assign software_power_off      = state.software_power_off;

  // checker history lives outside the state struct, so a broken run
  // counter in the design cannot also bend what the properties expect
  logic       chk_over;
  logic [1:0] chk_prior_over;

  assign chk_over = sense.conv_current[11:4] > current_alert_threshold;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chk_prior_over <= 2'h0;
    end else if (sense.conv_valid) begin
      chk_prior_over <= {chk_prior_over[0], chk_over};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_bits_high_zero: assert property (@(posedge clk) disable iff (reset)
    status_byte[7:6] == 2'b00) else $error("status bits 7 and 6 not zero");
  a_clear_self_ends: assert property (@(posedge clk) disable iff (reset)
    alert_en[AEN_CLEAR] && !wr.alert_en_we |=> !alert_en[AEN_CLEAR]) else $error("clear bit stuck");
  a_clear_drops_adc: assert property (@(posedge clk) disable iff (reset)
    alert_en[AEN_CLEAR] && !adc_event |=> !status_byte[BIT_ADC_ALERT]) else $error("adc alert not cleared");
  a_adc_sticky: assert property (@(posedge clk) disable iff (reset)
    status_byte[BIT_ADC_ALERT] && !alert_en[AEN_CLEAR] |=> status_byte[BIT_ADC_ALERT])
    else $error("adc alert dropped without clear");
  a_fail_sets: assert property (@(posedge clk) disable iff (reset)
    fail_event |=> status_byte[BIT_FAIL_ALERT]) else $error("fail alert not set");
  a_fail_sticky: assert property (@(posedge clk) disable iff (reset)
    status_byte[BIT_FAIL_ALERT] && !alert_en[AEN_CLEAR] |=> status_byte[BIT_FAIL_ALERT])
    else $error("fail alert dropped without clear");
  a_off_live: assert property (@(posedge clk) disable iff (reset)
    !$past(sense.on_pin) |-> status_byte[BIT_OFF_STATUS]) else $error("off status not set by pin");
  a_software_power_off_forces: assert property (@(posedge clk) disable iff (reset)
    $past(software_power_off) |-> status_byte[BIT_OFF_STATUS]) else $error("off status not set by soft off");
  a_off_alert_set: assert property (@(posedge clk) disable iff (reset)
    off_rise && alert_en[AEN_OFF] |=> status_byte[BIT_OFF_ALERT]) else $error("off alert not set");

  a_three_over: assert property (@(posedge clk) disable iff (reset)
    sense.conv_valid && chk_over && (&chk_prior_over)
    |=> status_byte[BIT_CONV_OC]) else $error("three over conversions not flagged");
  a_no_early_flag: assert property (@(posedge clk) disable iff (reset)
    sense.conv_valid && !(chk_over && (&chk_prior_over))
    |=> !status_byte[BIT_CONV_OC]) else $error("compare flag set too early");
  a_conv_bit_holds: assert property (@(posedge clk) disable iff (reset)
    !sense.conv_valid
    |=> status_byte[BIT_CONV_OC] == $past(status_byte[BIT_CONV_OC]))
    else $error("compare flag moved without conversion");
  a_at_threshold_under: assert property (@(posedge clk) disable iff (reset)
    sense.conv_valid && sense.conv_current[11:4] <= current_alert_threshold
    |=> !status_byte[BIT_CONV_OC]) else $error("conversion at threshold counted as over");
  a_under_clears: assert property (@(posedge clk) disable iff (reset)
    sense.conv_valid && !over_now |=> !status_byte[BIT_CONV_OC]) else $error("compare flag not dropped");
  a_trip_retry: assert property (@(posedge clk) disable iff (reset)
    !(LATCH_OFF && alert_en[AEN_FAIL]) |=> status_byte[BIT_TRIP_OFF] == $past(sense.analog_trip_off))
    else $error("trip bit not live");

  a_adc_sets: assert property (@(posedge clk) disable iff (reset)
    sense.conv_valid && chk_over && alert_en[AEN_OC1] && !wr.alert_en_we
    |=> ##1 status_byte[BIT_ADC_ALERT]) else $error("adc alert not set");
  a_trip_mirror: assert property (@(posedge clk) disable iff (reset)
    LATCH_OFF && alert_en[AEN_FAIL]
    |=> status_byte[BIT_TRIP_OFF] == status_byte[BIT_FAIL_ALERT])
    else $error("trip bit not mirroring failure flag");
  a_clear_drops_fail: assert property (@(posedge clk) disable iff (reset)
    alert_en[AEN_CLEAR] && !fail_event
    |=> !status_byte[BIT_FAIL_ALERT]) else $error("fail alert not cleared");
  a_clear_drops_off: assert property (@(posedge clk) disable iff (reset)
    alert_en[AEN_CLEAR] && !(off_rise && alert_en[AEN_OFF])
    |=> !status_byte[BIT_OFF_ALERT]) else $error("off alert not cleared");
  a_off_sticky: assert property (@(posedge clk) disable iff (reset)
    status_byte[BIT_OFF_ALERT] && !alert_en[AEN_CLEAR]
    |=> status_byte[BIT_OFF_ALERT]) else $error("off alert dropped without clear");
  a_off_needs_enable: assert property (@(posedge clk) disable iff (reset)
    !status_byte[BIT_OFF_ALERT] && !alert_en[AEN_OFF]
    |=> !status_byte[BIT_OFF_ALERT])
    else $error("off alert set while disabled");
  a_fail_needs_enable: assert property (@(posedge clk) disable iff (reset)
    !status_byte[BIT_FAIL_ALERT] && !(sense.swap_failed && alert_en[AEN_FAIL])
    |=> !status_byte[BIT_FAIL_ALERT])
    else $error("fail alert set without enabled failure");
  a_off_status_clear: assert property (@(posedge clk) disable iff (reset)
    sense.on_pin && !software_power_off
    |=> !status_byte[BIT_OFF_STATUS]) else $error("off status set while on");

  c_clear_seen: cover property (@(posedge clk) disable iff (reset) alert_en[AEN_CLEAR] ##1 !alert_en[AEN_CLEAR]);
  c_adc_alert: cover property (@(posedge clk) disable iff (reset) $rose(status_byte[BIT_ADC_ALERT]));
  c_off_alert: cover property (@(posedge clk) disable iff (reset) $rose(status_byte[BIT_OFF_ALERT]));
  c_conv_oc: cover property (@(posedge clk) disable iff (reset) $rose(status_byte[BIT_CONV_OC]));
  c_set_beats_clear: cover property (@(posedge clk) disable iff (reset)
    (alert_en[AEN_CLEAR] && adc_event) ##1 status_byte[BIT_ADC_ALERT]);
endmodule

// ---- hw/hsstat_pkg.sv ----
/*
  package for the hot swap status byte block: bit positions, reset values,
  register field layouts and the carrier structs.
  assumes nothing beyond a systemverilog compiler.
*/
package hsstat_pkg;
  // status byte bit positions
  localparam int unsigned BIT_CONV_OC      = 0;
  localparam int unsigned BIT_ADC_ALERT    = 1;
  localparam int unsigned BIT_TRIP_OFF     = 2;
  localparam int unsigned BIT_FAIL_ALERT   = 3;
  localparam int unsigned BIT_OFF_STATUS   = 4;
  localparam int unsigned BIT_OFF_ALERT    = 5;
  // alert-enable register bit positions
  localparam int unsigned AEN_OC1          = 0;
  localparam int unsigned AEN_OC4          = 1;
  localparam int unsigned AEN_FAIL         = 2;
  localparam int unsigned AEN_OFF          = 3;
  localparam int unsigned AEN_CLEAR        = 4;
  // reset values
  localparam logic [7:0] ALERT_EN_RESET    = 8'h04;
  localparam logic [7:0] THRESHOLD_RESET   = 8'hFF;
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  // conversions needed for the live compare flag and for the one- and four-in-a-row alerts
  localparam logic [2:0] OC_LIVE_COUNT     = 3'h3;
  localparam logic [2:0] OC_ALERT4_COUNT   = 3'h4;
  localparam logic [2:0] OC_ALERT1_COUNT   = 3'h1;

  // inputs from the analog front end and the adc
  typedef struct packed {
    logic        conv_valid;
    logic [11:0] conv_current;
    logic        analog_trip_off;
    logic        swap_failed;
    logic        on_pin;
  } hsstat_sense_t;

  // register writes arriving from the serial slave engine
  typedef struct packed {
    logic       alert_en_we;
    logic       threshold_we;
    logic       control_we;
    logic [7:0] wdata;
  } hsstat_wr_t;

  // all state of the block
  typedef struct packed {
    logic [7:0] alert_en;
    logic [7:0] current_alert_threshold;
    logic       software_power_off;
    logic [2:0] over_run;
    logic       conv_overcurrent_seen;
    logic       adc_alert;
    logic       swap_failure_flag;
    logic       off_alert;
    logic       prev_off;
    logic [7:0] hot_swap_status;
  } hsstat_state_t;
endpackage

// ---- dv/hsstat_master.sv ----
/*
  serial engine model: issues one-cycle register write strobes, fetches the status byte.
  assumes the bench owns the clock and calls the tasks by hierarchical name.
*/
`timescale 1ns/1ps
module hsstat_master (
  // clock
  input  wire logic                   clk,
  // register side of the block
  output hsstat_pkg::hsstat_wr_t      wr,
  input  wire logic [7:0]             status_byte
);
  import hsstat_pkg::*;
  initial wr = '0;
  // sel 0 alert-enable, 1 threshold, 2 control; strobe stands one cycle
  task automatic write_reg(input int sel, input logic [7:0] d);
    @(posedge clk);
    wr <= '{alert_en_we: sel == 0, threshold_we: sel == 1, control_we: sel == 2, wdata: d};
    @(posedge clk);
    wr <= '0;
  endtask
  // one read returns one byte
  task automatic fetch(output logic [7:0] b);
    b = status_byte;
  endtask
endmodule

// ---- dv/tb_hsstat_top.sv ----
/*
  self-checking bench for the status byte block, latch-off variant with a retry variant beside it.
  assumes hsstat_master drives the write strobes; expected bytes go through a queue.
*/
`timescale 1ns/1ps
module tb_hsstat_top;
  import hsstat_pkg::*;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  hsstat_sense_t sense;
  hsstat_wr_t    wr;
  logic [7:0]    status_byte, alert_en, current_alert_threshold;
  logic [7:0]    status_byte_retry;
  logic          software_power_off;
  logic [7:0]    expq[$];
  int            miscompares = 0;
  int            n_checks = 0;
  always #10 clk = ~clk;
  hsstat_top hsstat_top_inst (.clk(clk), .reset(reset), .sense(sense), .wr(wr), .status_byte(status_byte),
    .alert_en(alert_en), .current_alert_threshold(current_alert_threshold), .software_power_off(software_power_off));
  // retry variant shares all stimulus; only its status byte is compared
  hsstat_top #(.LATCH_OFF(1'b0)) hsstat_top_retry_inst (.clk(clk), .reset(reset), .sense(sense), .wr(wr),
    .status_byte(status_byte_retry), .alert_en(), .current_alert_threshold(), .software_power_off());
  hsstat_master hsstat_master_inst (.clk(clk), .wr(wr), .status_byte(status_byte));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // three edges cover the register latency, two cycles on the adc alert path, with margin
  task automatic expect_byte(input logic [7:0] e);
    repeat (3) @(posedge clk);
    expq.push_back(e);
  endtask
  // low nibble is random: only the top eight bits may matter
  task automatic conv(input logic [7:0] top);
    @(posedge clk);
    sense.conv_valid <= 1'b1;
    sense.conv_current <= {top, 4'($urandom)};
    @(posedge clk);
    sense.conv_valid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    logic [7:0] b;
    if (expq.size() > 0) begin
      hsstat_master_inst.fetch(b);
      check(b, expq.pop_front());
    end
  end
  initial begin
    void'($urandom(72));
    sense = '0;
    sense.on_pin = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(status_byte, 8'h00);
    check(current_alert_threshold, 8'hFF);
    check(alert_en, ALERT_EN_RESET);
    check({7'h00, software_power_off}, CONTROL_RESET);
    hsstat_master_inst.write_reg(1, 8'h80);
    @(negedge clk);
    check(current_alert_threshold, 8'h80);
    hsstat_master_inst.write_reg(0, 8'h0D);
    conv(8'h81);
    conv(8'h81);
    expect_byte(8'h02);
    conv(8'h81);
    expect_byte(8'h03);
    conv(8'h80);
    expect_byte(8'h02);
    sense.on_pin <= 1'b0;
    expect_byte(8'h32);
    sense.on_pin <= 1'b1;
    expect_byte(8'h22);
    hsstat_master_inst.write_reg(2, 8'h01);
    @(negedge clk);
    check({7'h00, software_power_off}, 8'h01);
    expect_byte(8'h32);
    hsstat_master_inst.write_reg(2, 8'h00);
    expect_byte(8'h22);
    @(posedge clk);
    sense.swap_failed <= 1'b1;
    @(posedge clk);
    sense.swap_failed <= 1'b0;
    expect_byte(8'h2E);
    @(negedge clk);
    check(status_byte_retry, 8'h2A);
    hsstat_master_inst.write_reg(0, 8'h1D);
    expect_byte(8'h00);
    @(negedge clk);
    check(alert_en, 8'h0D);
    hsstat_master_inst.write_reg(0, 8'h00);
    sense.analog_trip_off <= 1'b1;
    expect_byte(8'h04);
    sense.analog_trip_off <= 1'b0;
    @(negedge clk);
    check(status_byte_retry, 8'h04);
    expect_byte(8'h00);
    hsstat_master_inst.write_reg(0, 8'h02);
    repeat (3) conv(8'($urandom_range(255, 129)));
    expect_byte(8'h01);
    conv(8'($urandom_range(255, 129)));
    expect_byte(8'h03);
    hsstat_master_inst.write_reg(0, 8'h12);
    expect_byte(8'h03);
    @(negedge clk);
    check(alert_en, 8'h02);
    conv(8'($urandom_range(128, 0)));
    expect_byte(8'h02);
    hsstat_master_inst.write_reg(0, 8'h10);
    expect_byte(8'h00);
    repeat (4) @(negedge clk);
    if (expq.size() != 0) begin
      miscompares++;
    end
    conclude();
  end
endmodule
